/* File: verilog/indirect_mac_register_access.sv */
// host register file and bridge for indirect access to the mac register bank
`include "indirect_mac_map.svh"

module indirect_mac_register_access
    import indirect_mac_pkg::*;
#(
    parameter int ADDR_WIDTH = `HOST_ADDR_WIDTH
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // host processor port
    input  wire logic [ADDR_WIDTH-1:0] host_addr,
    input  wire logic                  host_wr,
    input  wire logic                  host_rd,
    input  wire logic [7:0]            host_wdata,
    output logic      [7:0]            host_rdata,
    // mac register bank
    output mac_request_type            mac_request,
    input  wire mac_response_type      mac_response
);

    // host visible byte registers
    logic [15:0] read_addr_reg;
    logic [15:0] read_addr_next;
    logic [15:0] write_addr_reg;
    logic [15:0] write_addr_next;
    logic [31:0] read_word_reg;
    logic [31:0] read_word_next;
    logic [31:0] write_word_reg;
    logic [31:0] write_word_next;
    logic        direction_reg;
    logic        direction_next;
    logic        pending_reg;
    logic        pending_next;
    logic [7:0]  host_rdata_reg;
    logic [7:0]  host_rdata_next;

    // latched request fields, frozen for the whole access
    logic        req_write_reg;
    logic        req_write_next;
    logic [15:0] req_addr_reg;
    logic [15:0] req_addr_next;
    logic [31:0] req_wdata_reg;
    logic [31:0] req_wdata_next;

    // sequencer outputs
    logic        seq_req;
    logic        seq_load;
    logic        seq_done;

    // byte lanes of the read and write words
    logic [3:0]  write_lane_strobe;
    logic [7:0]  read_word_lane  [4];
    logic [7:0]  write_word_lane [4];

    wire sel_read_addr_low   = host_addr == `OFS_READ_ADDR_LOW;
    wire sel_read_addr_high  = host_addr == `OFS_READ_ADDR_HIGH;
    wire sel_read_data_byte0 = host_addr == `OFS_READ_DATA_BYTE0;
    wire sel_read_data_byte1 = host_addr == `OFS_READ_DATA_BYTE1;
    wire sel_read_data_byte2 = host_addr == `OFS_READ_DATA_BYTE2;
    wire sel_read_data_byte3 = host_addr == `OFS_READ_DATA_BYTE3;
    wire sel_write_data_b0   = host_addr == `OFS_WRITE_DATA_BYTE0;
    wire sel_write_data_b1   = host_addr == `OFS_WRITE_DATA_BYTE1;
    wire sel_write_data_b2   = host_addr == `OFS_WRITE_DATA_BYTE2;
    wire sel_write_data_b3   = host_addr == `OFS_WRITE_DATA_BYTE3;
    wire sel_write_addr_low  = host_addr == `OFS_WRITE_ADDR_LOW;
    wire sel_write_addr_high = host_addr == `OFS_WRITE_ADDR_HIGH;
    wire sel_command         = host_addr == `OFS_COMMAND;

    // host write strobes
    wire wr_read_addr_low   = host_wr && sel_read_addr_low;
    wire wr_read_addr_high  = host_wr && sel_read_addr_high;
    wire wr_write_data_b0   = host_wr && sel_write_data_b0;
    wire wr_write_data_b1   = host_wr && sel_write_data_b1;
    wire wr_write_data_b2   = host_wr && sel_write_data_b2;
    wire wr_write_data_b3   = host_wr && sel_write_data_b3;
    wire wr_write_addr_low  = host_wr && sel_write_addr_low;
    wire wr_write_addr_high = host_wr && sel_write_addr_high;
    wire wr_command         = host_wr && sel_command;

    // command register accepts writes only while no access runs
    wire command_idle = !pending_reg;

    // launch on a one written to the pending flag
    wire launch_request = wr_command && host_wdata[`CMD_PENDING_BIT] && command_idle;
    wire launch_is_read = host_wdata[`CMD_DIRECTION_BIT];

    assign read_addr_next[7:0]  = wr_read_addr_low  ? host_wdata : read_addr_reg[7:0];
    assign read_addr_next[15:8] = wr_read_addr_high ? host_wdata : read_addr_reg[15:8];

    // write address low and high bytes, kept apart from the read address
    assign write_addr_next[7:0]  = wr_write_addr_low  ? host_wdata : write_addr_reg[7:0];
    assign write_addr_next[15:8] = wr_write_addr_high ? host_wdata : write_addr_reg[15:8];

    // write strobes gathered by byte lane
    assign write_lane_strobe = {wr_write_data_b3, wr_write_data_b2,
                                wr_write_data_b1, wr_write_data_b0};

    // write word bytes, byte 0 in the low lane; read word split alike
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_byte_lane
            assign write_word_next[8*lane +: 8] = write_lane_strobe[lane] ?
                                                  host_wdata : write_word_reg[8*lane +: 8];
            assign read_word_lane[lane]         = read_word_reg[8*lane +: 8];
            assign write_word_lane[lane]        = write_word_reg[8*lane +: 8];
        end
    endgenerate

    // capture on the acknowledge, two cycles before the pending flag clears
    wire read_capture = seq_load && !req_write_reg;

    // read word captured from the mac on the read acknowledge
    assign read_word_next = read_capture ? mac_response.rdata : read_word_reg;

    // direction bit is host writable only while no access runs
    assign direction_next = (wr_command && command_idle) ?
                            host_wdata[`CMD_DIRECTION_BIT] : direction_reg;

    // pending flag: set by launch, cleared by completion
    assign pending_next = launch_request ? 1'b1 :
                          seq_done       ? 1'b0 : pending_reg;

    // address choice follows the launched direction
    assign req_addr_next  = launch_request ? (launch_is_read ? read_addr_reg : write_addr_reg)
                                           : req_addr_reg;
    // write address never used by a read
    assign req_write_next = launch_request ? !launch_is_read : req_write_reg;
    assign req_wdata_next = launch_request ? write_word_reg : req_wdata_reg;

    // command register as the host reads it
    wire [7:0] command_view = {6'h00, direction_reg, pending_reg};

    // host read multiplexer; unmapped addresses read as zero
    assign host_rdata_next = !host_rd             ? host_rdata_reg :
                             sel_read_addr_low    ? read_addr_reg[7:0] :
                             sel_read_addr_high   ? read_addr_reg[15:8] :
                             sel_read_data_byte0  ? read_word_lane[0] :
                             sel_read_data_byte1  ? read_word_lane[1] :
                             sel_read_data_byte2  ? read_word_lane[2] :
                             sel_read_data_byte3  ? read_word_lane[3] :
                             sel_write_data_b0    ? write_word_lane[0] :
                             sel_write_data_b1    ? write_word_lane[1] :
                             sel_write_data_b2    ? write_word_lane[2] :
                             sel_write_data_b3    ? write_word_lane[3] :
                             sel_write_addr_low   ? write_addr_reg[7:0] :
                             sel_write_addr_high  ? write_addr_reg[15:8] :
                             sel_command          ? command_view :
                                                    `UNMAPPED_READ;

    // handshake sequencer
    indirect_mac_sequencer u_sequencer (
        .clk        (clk),
        .rst        (rst),
        .launch     (launch_request),
        .mac_ack    (mac_response.ack),
        .req_reg    (seq_req),
        .load_pulse (seq_load),
        .done_reg   (seq_done)
    );

    // read address bytes clear at reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            read_addr_reg <= `ADDR_RESET;
        end
        else
        begin
            read_addr_reg <= read_addr_next;
        end
    end

    // write address bytes clear at reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            write_addr_reg <= `ADDR_RESET;
        end
        else
        begin
            write_addr_reg <= write_addr_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            read_word_reg <= `WORD_RESET;
        end
        else
        begin
            read_word_reg <= read_word_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            write_word_reg <= `WORD_RESET;
        end
        else
        begin
            write_word_reg <= write_word_next;
        end
    end

    // direction bit of the command register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            direction_reg <= 1'b0;
        end
        else
        begin
            direction_reg <= direction_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pending_reg <= 1'b0;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    // host read data holds until the next read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            host_rdata_reg <= `BYTE_RESET;
        end
        else
        begin
            host_rdata_reg <= host_rdata_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_write_reg <= 1'b0;
        end
        else
        begin
            req_write_reg <= req_write_next;
        end
    end

    // address of the launched access, frozen until the next launch
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_addr_reg <= `ADDR_RESET;
        end
        else
        begin
            req_addr_reg <= req_addr_next;
        end
    end

    // write word frozen at launch until the mac has taken it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_wdata_reg <= `WORD_RESET;
        end
        else
        begin
            req_wdata_reg <= req_wdata_next;
        end
    end

    // outputs straight from flops
    assign host_rdata        = host_rdata_reg;
    assign mac_request.req   = seq_req;
    assign mac_request.write = req_write_reg;
    assign mac_request.addr  = req_addr_reg;
    assign mac_request.wdata = req_wdata_reg;

endmodule : indirect_mac_register_access

/* File: verilog/indirect_mac_map.svh */
// address width, register offsets, field positions, reset values and unmapped read value of the indirect mac port
`ifndef INDIRECT_MAC_MAP_SVH
`define INDIRECT_MAC_MAP_SVH

// host port address width
`define HOST_ADDR_WIDTH 9

// register offsets on the host port
`define OFS_READ_ADDR_LOW   9'h140
`define OFS_READ_ADDR_HIGH  9'h141
`define OFS_READ_DATA_BYTE0 9'h142
`define OFS_READ_DATA_BYTE1 9'h143
`define OFS_READ_DATA_BYTE2 9'h144
`define OFS_READ_DATA_BYTE3 9'h145
`define OFS_WRITE_DATA_BYTE0 9'h146
`define OFS_WRITE_DATA_BYTE1 9'h147
`define OFS_WRITE_DATA_BYTE2 9'h148
`define OFS_WRITE_DATA_BYTE3 9'h149
`define OFS_WRITE_ADDR_LOW  9'h14A
`define OFS_WRITE_ADDR_HIGH 9'h14B
`define OFS_COMMAND         9'h14C

// command register fields
`define CMD_PENDING_BIT   0
`define CMD_DIRECTION_BIT 1

// reset values
`define BYTE_RESET 8'h00
`define WORD_RESET 32'h0000_0000
`define ADDR_RESET 16'h0000

// value that an unmapped address reads
`define UNMAPPED_READ 8'h00

`endif

/* File: verilog/indirect_mac_pkg.sv */
// types shared by the indirect mac access port
package indirect_mac_pkg;

    // request towards the mac register bank
    typedef struct packed {
        logic        req;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } mac_request_type;

    // answer from the mac register bank
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mac_response_type;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_WAIT   = 2'b01,
        SEQ_FINISH = 2'b10
    } seq_state_type;

endpackage : indirect_mac_pkg

/* File: verilog/indirect_mac_sequencer.sv */
// handshake sequencer that runs one indirect mac access
module indirect_mac_sequencer
    import indirect_mac_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // command side
    input  wire logic launch,
    input  wire logic mac_ack,
    // results
    output logic      req_reg,
    output logic      load_pulse,
    output logic      done_reg
);

    seq_state_type state_reg;
    seq_state_type state_next;
    logic          req_next;
    logic          done_next;

    // next state: hold the request until the mac acknowledges
    always_comb
    begin
        state_next = state_reg;
        req_next   = req_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            SEQ_IDLE:
            begin
                if (launch)
                begin
                    state_next = SEQ_WAIT;
                    req_next   = 1'b1;
                end
            end
            SEQ_WAIT:
            begin
                if (mac_ack)
                begin
                    state_next = SEQ_FINISH;
                    req_next   = 1'b0;
                end
            end
            SEQ_FINISH:
            begin
                state_next = SEQ_IDLE;
                done_next  = 1'b1;
            end
            default:
            begin
                state_next = SEQ_IDLE;
                req_next   = 1'b0;
            end
        endcase
    end

    // ack in the wait state captures the read word one cycle ahead of done
    assign load_pulse = (state_reg == SEQ_WAIT) && mac_ack;

    // state registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= SEQ_IDLE;
            req_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            req_reg   <= req_next;
            done_reg  <= done_next;
        end
    end

endmodule : indirect_mac_sequencer

/* File: bench/indirect_mac_chk.sv */
// concurrent checks on the ports of the indirect mac access port
module indirect_mac_chk
    import indirect_mac_pkg::*;
#(
    parameter int ADDR_WIDTH = 9
)
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // host processor port
    input wire logic [ADDR_WIDTH-1:0] host_addr,
    input wire logic                  host_wr,
    input wire logic                  host_rd,
    input wire logic [7:0]            host_wdata,
    input wire logic [7:0]            host_rdata,
    // mac register bank
    input wire mac_request_type       mac_request,
    input wire mac_response_type      mac_response
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic        busy_reg;
    logic        done_d1_reg;
    logic        done_d2_reg;
    logic [31:0] word_reg;
    // launch seen from the ports, access completion and expected read byte
    wire        launch  = host_wr && host_addr == 9'h14C && host_wdata[0] && !busy_reg;
    wire        done    = mac_request.req && mac_response.ack;
    wire [31:0] shifted = word_reg >> {host_addr[1:0] - 2'd2, 3'b000};
    // mirror of the pending flag, which clears two cycles after the acknowledge
    always_ff @(posedge clk)
    begin
        done_d1_reg <= !rst && done;
        done_d2_reg <= !rst && done_d1_reg;
        busy_reg    <= !rst && (launch || (busy_reg && !done_d2_reg));
        word_reg <= rst ? 32'h0 : (done && !mac_request.write ? mac_response.rdata : word_reg);
    end
    sequence s_launch_read;
        launch && host_wdata[1];
    endsequence
    sequence s_launch_write;
        launch && !host_wdata[1];
    endsequence
    a_launch_read: assert property (s_launch_read |=> mac_request.req && !mac_request.write)
        else $error("read launch gave no read request");
    a_launch_write: assert property (s_launch_write |=> mac_request.req && mac_request.write)
        else $error("write launch gave no write request");
    a_req_only_busy: assert property (!busy_reg |-> !mac_request.req)
        else $error("request raised with no command pending");
    a_req_holds_ack: assert property (mac_request.req && !mac_response.ack |=> mac_request.req)
        else $error("request dropped before acknowledge");
    a_fields_stable: assert property (mac_request.req && !mac_response.ack |=>
        $stable(mac_request.addr) && $stable(mac_request.wdata) && $stable(mac_request.write))
        else $error("request fields moved during access");
    a_req_drops_ack: assert property (done |=> !mac_request.req ##1 !mac_request.req)
        else $error("request not released after acknowledge");
    a_read_bytes: assert property (host_rd && host_addr inside {[9'h142:9'h145]} && !busy_reg
        |=> host_rdata == $past(shifted[7:0]))
        else $error("read byte does not match word from mac");
    a_pending_shown: assert property (s_launch_read ##1 (host_rd && host_addr == 9'h14C)
        |=> host_rdata == 8'h03)
        else $error("command register does not show pending read");
    a_unmapped_zero: assert property (host_rd && (host_addr < 9'h140 || host_addr > 9'h14C)
        |=> host_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
        else $error("read data changed without a read");
endmodule : indirect_mac_chk

bind indirect_mac_register_access indirect_mac_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_inst
(
    .clk(clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .mac_request(mac_request),
    .mac_response(mac_response)
);

/* File: bench/mac_bank_model.sv */
// behavioural mac register bank answering the indirect port
module mac_bank_model
    import indirect_mac_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // stall length chosen by the bench
    input  wire logic [3:0]      wait_cycles,
    // request and answer
    input  wire mac_request_type mac_request,
    output mac_response_type     mac_response
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [16];
    logic [3:0]  cnt_reg;
    // one acknowledge after the stall; read data only valid with it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mac_response <= '0;
            cnt_reg      <= '0;
        end
        else if (mac_request.req && !mac_response.ack && cnt_reg == wait_cycles)
        begin
            mac_response.ack   <= 1'b1;
            mac_response.rdata <= mem[mac_request.addr[3:0]];
            if (mac_request.write)
                mem[mac_request.addr[3:0]] <= mac_request.wdata;
            cnt_reg <= '0;
        end
        else
        begin
            mac_response.ack   <= 1'b0;
            mac_response.rdata <= ~mac_response.rdata;  // stale word inverted each cycle, so it is never held steady
            cnt_reg <= (mac_request.req && !mac_response.ack) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule : mac_bank_model

/* File: bench/indirect_mac_register_access_bench.sv */
// self-checking bench of the indirect mac access port
module indirect_mac_register_access_bench
    import indirect_mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk = 0, rst = 1, host_wr = 0, host_rd = 0, chk = 0, seen = 0;
    logic [8:0]       host_addr = '0;
    logic [7:0]       host_wdata = '0, host_rdata;
    logic [3:0]       wait_cycles = '0;
    logic [31:0]      wd, wa;
    logic [7:0]       exp_q[$];
    mac_request_type  mac_request;
    mac_response_type mac_response;
    int               failures = 0, compares = 0, seed = 87, i, k;
    always #2.5 clk = ~clk;
    indirect_mac_register_access indirect_mac_register_access_inst (.clk(clk), .rst(rst),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .mac_request(mac_request), .mac_response(mac_response));
    mac_bank_model mac_bank_model_inst (.clk(clk), .rst(rst), .wait_cycles(wait_cycles),
        .mac_request(mac_request), .mac_response(mac_response));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp32
    // one host cycle; every strobe assigned once per step
    task automatic op(input logic w, r, c, input logic [8:0] a, input logic [7:0] d, e);
        host_wr = w;
        host_rd = r;
        chk = c;
        host_addr = a;
        host_wdata = d;
        if (c)
            exp_q.push_back(e);
        @(posedge clk) #1;
    endtask : op
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, 1'b0, a, d, 8'h00);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        op(1'b0, 1'b1, 1'b1, a, 8'h00, e);
    endtask : rd
    // poll the pending flag under a bounded count
    task automatic poll();
        for (k = 0; k < 60; k++)
        begin
            op(1'b0, 1'b1, 1'b0, 9'h14C, 8'h00, 8'h00);
            if (host_rdata[0] === 1'b0)
                break;
        end
        if (k == 60)
            failures++;
    endtask : poll
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // result watcher: oldest expected byte against the answer
    always @(posedge clk)
    begin
        if (seen && exp_q.size() > 0)
            cmp8(host_rdata, exp_q.pop_front());
        seen = host_rd && chk;
    end
    initial
    begin
        #100000;
        failures++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = 0;
        for (i = 9'h140; i <= 9'h14C; i++) rd(i[8:0], 8'h00);
        $display("test reset values done");
        for (i = 0; i < 6; i++)
        begin
            wd = $random(seed);
            wa = $random(seed);
            wait_cycles = 4'(i * 3);
            for (k = 0; k < 4; k++) wr(9'(9'h146 + k), wd[8*k +: 8]);
            wr(9'h14A, wa[7:0]);
            wr(9'h14B, wa[15:8]);
            wr(9'h140, ~wa[7:0]);
            wr(9'h14C, 8'h01);
            poll();
            cmp32(mac_bank_model_inst.mem[wa[3:0]], wd);
            cmp32({16'h0000, mac_request.addr}, {16'h0000, wa[15:0]});
            for (k = 0; k < 4; k++) rd(9'(9'h146 + k), wd[8*k +: 8]);
            rd(9'h14C, 8'h00);
            wr(9'h14A, ~wa[7:0]);
            wr(9'h140, wa[7:0]);
            wr(9'h141, wa[15:8]);
            wr(9'h14C, 8'h03);
            rd(9'h14C, 8'h03);
            poll();
            cmp32({16'h0000, mac_request.addr}, {16'h0000, wa[15:0]});
            rd(9'h14C, 8'h02);
            for (k = 0; k < 4; k++) rd(9'(9'h142 + k), wd[8*k +: 8]);
        end
        $display("test write and read commands done");
        wait_cycles = 4'hC;
        wr(9'h146, ~wd[7:0]);
        wr(9'h142, 8'hA5);
        wr(9'h14A, wa[7:0]);
        wr(9'h14C, 8'h03);
        wr(9'h14C, 8'h01);
        poll();
        cmp32({16'h0000, mac_request.addr}, {16'h0000, wa[15:0]});
        rd(9'h14C, 8'h02);
        rd(9'h142, wd[7:0]);
        cmp32(mac_bank_model_inst.mem[wa[3:0]], wd);
        rd(9'h13F, 8'h00);
        rd(9'h14D, 8'h00);
        rd(9'h000, 8'h00);
        op(1'b0, 1'b0, 1'b0, 9'h000, 8'h00, 8'h00);
        op(1'b0, 1'b0, 1'b0, 9'h000, 8'h00, 8'h00);
        $display("test refused accesses done");
        summarize();
    end
endmodule : indirect_mac_register_access_bench
